// [hw/eam_pkg.sv]
package eam_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_ACCUM_MODE = 8'h0f;
  localparam logic [7:0] IDX_CHANNEL_GAIN = 8'h1b;
  localparam logic [7:0] IDX_CALIB_MODE = 8'h3d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam logic [7:0] IDX_TAMPER_CTRL = 8'h42;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ACCUM_MODE = 8'h00;
  localparam logic [7:0] RST_CHANNEL_GAIN = 8'h00;
  localparam logic [7:0] RST_CALIB_MODE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ACC_ACTIVE_INPUT = 7;
  localparam int ACC_FAULT_SEL = 6;
  localparam int ACC_REACT_SIGN_SEL = 5;
  localparam int ACC_ACT_SIGN_SEL = 4;
  localparam int ACC_REACT_ABS = 3;
  localparam int ACC_REACT_FOLLOW = 2;
  localparam int ACC_ACT_POS_ONLY = 1;
  localparam int ACC_ACT_ABS = 0;
  localparam int GAIN_V_LSB = 5;
  localparam int GAIN_SIGN_POINT = 3;
  localparam int GAIN_I_LSB = 0;
  localparam int CAL_SEL_LSB = 4;
  localparam int CAL_V_GROUND = 3;
  localparam int CAL_I_GROUND = 2;
  localparam logic [7:0] ACC_WRITE_MASK = 8'h7f;
  localparam logic [7:0] GAIN_WRITE_MASK = 8'hef;
  localparam logic [7:0] CAL_WRITE_MASK = 8'h3c;

  // ----------------------------------------
  // interrupt bits
  // ----------------------------------------
  localparam int IRQ_ACT_SIGN = 0;
  localparam int IRQ_REACT_SIGN = 1;
  localparam int IRQ_FAULT = 2;

  // ----------------------------------------
  // gain and input select codes
  // ----------------------------------------
  localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
  localparam logic [1:0] SEL_INPUT_A = 2'h1;
  localparam logic [1:0] SEL_INPUT_B = 2'h2;

  typedef enum logic [1:0] {
    EAM_IDLE,
    EAM_ACK
  } eam_bus_st_t;

  typedef struct packed {
    logic [7:0] accum_mode;
    logic [7:0] channel_gain;
    logic [7:0] calib_mode;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic tamper_auto_b;
    logic act_neg;
    logic react_neg;
    logic fault_prev;
    logic [2:0] fault_sync;
    logic sign_valid;
    eam_bus_st_t bus_st;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] act_out;
    logic [31:0] react_out;
    logic act_out_vld;
    logic react_out_vld;
    logic [31:0] i_sample;
    logic [31:0] v_sample;
    logic [4:0] i_gain;
    logic [4:0] v_gain;
  } eam_state_t;

endpackage : eam_pkg

// [hw/eam_config.sv]
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - status bit shows input used, A=0 B=1
// - fault event on entry or on return
// - reactive sign event direction by select bit
// - active sign event direction by select bit
// - reactive absolute mode accumulates magnitude
// - reactive negated while active power negative
// - positive-only active accumulation
// - active absolute mode accumulates magnitude
// - voltage gain code bits 7:5, 1..16
// - current gain code bits 2:0, 1..16
// - sign detection on filtered or per pulse
// - input select 01=A 10=B else automatic
// - voltage ground bit zeroes voltage input
// - current ground bit zeroes current input
// - active sign flag set on chosen change
module eam_config (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic signed [31:0] act_power_i,
  input wire logic signed [31:0] react_power_i,
  input wire logic power_vld_i,
  input wire logic act_pulse_neg_i,
  input wire logic react_pulse_neg_i,
  input wire logic pulse_vld_i,
  input wire logic fault_mode_i,
  input wire logic tamper_b_i,
  input wire logic signed [31:0] cur_a_i,
  input wire logic signed [31:0] cur_b_i,
  input wire logic signed [31:0] volt_i,
  output logic signed [31:0] act_accum_o,
  output logic signed [31:0] react_accum_o,
  output logic act_accum_vld_o,
  output logic react_accum_vld_o,
  output logic signed [31:0] cur_sample_o,
  output logic signed [31:0] volt_sample_o,
  output logic [4:0] cur_gain_o,
  output logic [4:0] volt_gain_o
);

  eam_pkg::eam_state_t st_ff;
  eam_pkg::eam_state_t nxt_st;

  // ----------------------------------------
  // gain decode
  // ----------------------------------------
  function automatic logic [4:0] gain_of(input logic [2:0] code);
    logic [4:0] g;
    g = 5'h01;
    if (code <= eam_pkg::GAIN_CODE_MAX) begin
      g = 5'(5'h01 << code);
    end
    return g;
  endfunction : gain_of

  function automatic logic [31:0] negate(input logic [31:0] x);
    return 32'(32'h0 - x);
  endfunction : negate

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic acc_hit;
  logic gain_hit;
  logic cal_hit;
  logic sts_hit;
  logic msk_hit;
  logic tam_hit;
  logic [7:0] idx;
  assign idx = wb_adr_i[9:2];

  always_comb begin
    acc_hit = 1'b0;
    gain_hit = 1'b0;
    cal_hit = 1'b0;
    sts_hit = 1'b0;
    msk_hit = 1'b0;
    tam_hit = 1'b0;
    if (idx == eam_pkg::IDX_ACCUM_MODE) begin
      acc_hit = 1'b1;
    end else if (idx == eam_pkg::IDX_CHANNEL_GAIN) begin
      gain_hit = 1'b1;
    end else if (idx == eam_pkg::IDX_CALIB_MODE) begin
      cal_hit = 1'b1;
    end else if (idx == eam_pkg::IDX_IRQ_STATUS) begin
      sts_hit = 1'b1;
    end else if (idx == eam_pkg::IDX_IRQ_MASK) begin
      msk_hit = 1'b1;
    end else if (idx == eam_pkg::IDX_TAMPER_CTRL) begin
      tam_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic take;
  logic wr;
  logic [2:0] ev;
  logic act_now_neg;
  logic react_now_neg;
  logic fault_now;
  logic use_b;
  logic [31:0] act_v;
  logic [31:0] react_v;
  logic [7:0] acc;
  logic [7:0] cal;
  logic [7:0] gn;
  logic sign_tick;
  logic sign_act_neg;
  logic sign_react_neg;
  logic act_to_neg;
  logic act_to_pos;
  logic react_to_neg;
  logic react_to_pos;
  logic fault_settled;
  logic fault_enter;
  logic fault_leave;

  always_comb begin
    nxt_st = st_ff;
    ev = 3'h0;
    acc = st_ff.accum_mode;
    cal = st_ff.calib_mode;
    gn = st_ff.channel_gain;
    take = wb_cyc_i && wb_stb_i && (st_ff.bus_st == eam_pkg::EAM_IDLE);
    wr = take && wb_we_i && wb_sel_i[0];
    act_now_neg = st_ff.act_neg;
    react_now_neg = st_ff.react_neg;
    act_v = 32'h0;
    react_v = 32'h0;
    fault_now = st_ff.fault_sync[2];

    // ----------------------------------------
    // sign tap point
    // ----------------------------------------
    if (gn[eam_pkg::GAIN_SIGN_POINT]) begin
      sign_tick = pulse_vld_i;
      sign_act_neg = act_pulse_neg_i;
      sign_react_neg = react_pulse_neg_i;
    end else begin
      sign_tick = power_vld_i;
      sign_act_neg = act_power_i[31];
      sign_react_neg = react_power_i[31];
    end
    if (sign_tick) begin
      act_now_neg = sign_act_neg;
      react_now_neg = sign_react_neg;
    end
    nxt_st.act_neg = act_now_neg;
    nxt_st.react_neg = react_now_neg;
    nxt_st.sign_valid = st_ff.sign_valid | sign_tick;

    // ----------------------------------------
    // sign change events
    // ----------------------------------------
    act_to_neg = !st_ff.act_neg && act_now_neg;
    act_to_pos = st_ff.act_neg && !act_now_neg;
    react_to_neg = !st_ff.react_neg && react_now_neg;
    react_to_pos = st_ff.react_neg && !react_now_neg;
    // first valid sample only primes the sign history
    if (st_ff.sign_valid) begin
      if (acc[eam_pkg::ACC_ACT_SIGN_SEL]) begin
        ev[eam_pkg::IRQ_ACT_SIGN] = act_to_pos;
      end else begin
        ev[eam_pkg::IRQ_ACT_SIGN] = act_to_neg;
      end
      if (acc[eam_pkg::ACC_REACT_SIGN_SEL]) begin
        ev[eam_pkg::IRQ_REACT_SIGN] = react_to_pos;
      end else begin
        ev[eam_pkg::IRQ_REACT_SIGN] = react_to_neg;
      end
    end

    // ----------------------------------------
    // fault pin: three stage, change once 2nd and 3rd agree
    // ----------------------------------------
    nxt_st.fault_sync = {st_ff.fault_sync[1:0], fault_mode_i};
    fault_settled = (st_ff.fault_sync[2] == st_ff.fault_sync[1]);
    fault_enter = fault_settled && !st_ff.fault_prev && fault_now;
    fault_leave = fault_settled && st_ff.fault_prev && !fault_now;
    if (fault_settled) begin
      nxt_st.fault_prev = fault_now;
    end
    if (acc[eam_pkg::ACC_FAULT_SEL]) begin
      ev[eam_pkg::IRQ_FAULT] = fault_leave;
    end else begin
      ev[eam_pkg::IRQ_FAULT] = fault_enter;
    end

    // ----------------------------------------
    // current input choice
    // ----------------------------------------
    use_b = st_ff.tamper_auto_b;
    if (cal[eam_pkg::CAL_SEL_LSB +: 2] == eam_pkg::SEL_INPUT_A) begin
      use_b = 1'b0;
    end else if (cal[eam_pkg::CAL_SEL_LSB +: 2] == eam_pkg::SEL_INPUT_B) begin
      use_b = 1'b1;
    end
    nxt_st.accum_mode[eam_pkg::ACC_ACTIVE_INPUT] = use_b;

    // ----------------------------------------
    // sample path and gains
    // ----------------------------------------
    if (use_b) begin
      nxt_st.i_sample = cur_b_i;
    end else begin
      nxt_st.i_sample = cur_a_i;
    end
    if (cal[eam_pkg::CAL_I_GROUND]) begin
      nxt_st.i_sample = 32'h0;
    end
    if (cal[eam_pkg::CAL_V_GROUND]) begin
      nxt_st.v_sample = 32'h0;
    end else begin
      nxt_st.v_sample = volt_i;
    end
    nxt_st.v_gain = gain_of(gn[eam_pkg::GAIN_V_LSB +: 3]);
    nxt_st.i_gain = gain_of(gn[eam_pkg::GAIN_I_LSB +: 3]);

    // ----------------------------------------
    // active accumulation shaping
    // ----------------------------------------
    act_v = act_power_i;
    if (acc[eam_pkg::ACC_ACT_ABS] && act_power_i[31]) begin
      act_v = negate(act_power_i);
    end else if (acc[eam_pkg::ACC_ACT_POS_ONLY] && act_power_i[31]) begin
      act_v = 32'h0;
    end

    // ----------------------------------------
    // reactive accumulation shaping
    // ----------------------------------------
    react_v = react_power_i;
    if (acc[eam_pkg::ACC_REACT_ABS]) begin
      if (react_power_i[31]) begin
        react_v = negate(react_power_i);
      end
    end else if (acc[eam_pkg::ACC_REACT_FOLLOW] && act_power_i[31]) begin
      react_v = negate(react_power_i);
    end
    nxt_st.act_out_vld = power_vld_i;
    nxt_st.react_out_vld = power_vld_i;
    if (power_vld_i) begin
      nxt_st.act_out = act_v;
      nxt_st.react_out = react_v;
    end

    // ----------------------------------------
    // bus slave read
    // ----------------------------------------
    nxt_st.rdata = 32'h0;
    if (take) begin
      nxt_st.bus_st = eam_pkg::EAM_ACK;
      if (acc_hit) begin
        nxt_st.rdata = {24'h0, nxt_st.accum_mode};
      end else if (gain_hit) begin
        nxt_st.rdata = {24'h0, gn};
      end else if (cal_hit) begin
        nxt_st.rdata = {24'h0, cal};
      end else if (sts_hit) begin
        nxt_st.rdata = {29'h0, st_ff.irq_status};
      end else if (msk_hit) begin
        nxt_st.rdata = {29'h0, st_ff.irq_mask};
      end else if (tam_hit) begin
        nxt_st.rdata = {31'h0, st_ff.tamper_auto_b};
      end
    end else begin
      nxt_st.bus_st = eam_pkg::EAM_IDLE;
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr && acc_hit) begin
      nxt_st.accum_mode = (wb_dat_i[7:0] & eam_pkg::ACC_WRITE_MASK) | {use_b, 7'h0};
    end else if (wr && gain_hit) begin
      nxt_st.channel_gain = wb_dat_i[7:0] & eam_pkg::GAIN_WRITE_MASK;
    end else if (wr && cal_hit) begin
      nxt_st.calib_mode = wb_dat_i[7:0] & eam_pkg::CAL_WRITE_MASK;
    end else if (wr && msk_hit) begin
      nxt_st.irq_mask = wb_dat_i[2:0];
    end else if (wr && tam_hit) begin
      nxt_st.tamper_auto_b = wb_dat_i[0];
    end

    // ----------------------------------------
    // sticky status, read clears, event wins
    // ----------------------------------------
    nxt_st.irq_status = st_ff.irq_status;
    if (take && !wb_we_i && sts_hit) begin
      nxt_st.irq_status = 3'h0;
    end
    nxt_st.irq_status = nxt_st.irq_status | ev;
    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);

    // ----------------------------------------
    // tamper latch
    // ----------------------------------------
    if (tamper_b_i) begin
      nxt_st.tamper_auto_b = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.accum_mode <= eam_pkg::RST_ACCUM_MODE;
      st_ff.channel_gain <= eam_pkg::RST_CHANNEL_GAIN;
      st_ff.calib_mode <= eam_pkg::RST_CALIB_MODE;
      st_ff.irq_status <= eam_pkg::RST_IRQ;
      st_ff.irq_mask <= eam_pkg::RST_IRQ;
      st_ff.i_gain <= 5'h01;
      st_ff.v_gain <= 5'h01;
      st_ff.bus_st <= eam_pkg::EAM_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = (st_ff.bus_st == eam_pkg::EAM_ACK);
  assign irq_o = st_ff.irq;
  assign act_accum_o = st_ff.act_out;
  assign react_accum_o = st_ff.react_out;
  assign act_accum_vld_o = st_ff.act_out_vld;
  assign react_accum_vld_o = st_ff.react_out_vld;
  assign cur_sample_o = st_ff.i_sample;
  assign volt_sample_o = st_ff.v_sample;
  assign cur_gain_o = st_ff.i_gain;
  assign volt_gain_o = st_ff.v_gain;

endmodule : eam_config
`default_nettype wire

// [tb/eam_config_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module eam_config_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic signed [31:0] act_power_i,
  input wire logic power_vld_i,
  input wire logic signed [31:0] act_accum_o,
  input wire logic act_accum_vld_o,
  input wire logic signed [31:0] volt_i,
  input wire logic signed [31:0] volt_sample_o,
  input wire logic signed [31:0] cur_a_i,
  input wire logic signed [31:0] cur_b_i,
  input wire logic signed [31:0] cur_sample_o,
  input wire logic [4:0] cur_gain_o,
  input wire logic [4:0] volt_gain_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_next; $rose(wb_stb_i) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_rst_out; $fell(rst_i) |-> !wb_ack_o && !irq_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
  property p_vld; act_accum_vld_o == $past(power_vld_i); endproperty
  a_vld: assert property (p_vld) else $error("valid timing");
  property p_act;
    act_accum_vld_o |-> act_accum_o == $past(act_power_i) || act_accum_o == -$past(act_power_i) || act_accum_o == 0;
  endproperty
  a_act: assert property (p_act) else $error("active shape");
  property p_volt; volt_sample_o == 0 || volt_sample_o == $past(volt_i); endproperty
  a_volt: assert property (p_volt) else $error("voltage sample");
  property p_cur;
    cur_sample_o == 0 || cur_sample_o == $past(cur_a_i) || cur_sample_o == $past(cur_b_i);
  endproperty
  a_cur: assert property (p_cur) else $error("current sample");
  property p_gain; $onehot(cur_gain_o) && $onehot(volt_gain_o); endproperty
  a_gain: assert property (p_gain) else $error("gain value");
endmodule : eam_config_asserts
bind eam_config eam_config_asserts eam_config_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .act_power_i(act_power_i), .power_vld_i(power_vld_i),
  .act_accum_o(act_accum_o), .act_accum_vld_o(act_accum_vld_o), .volt_i(volt_i), .volt_sample_o(volt_sample_o),
  .cur_a_i(cur_a_i), .cur_b_i(cur_b_i), .cur_sample_o(cur_sample_o), .cur_gain_o(cur_gain_o),
  .volt_gain_o(volt_gain_o));
`default_nettype wire

// [tb/tb_energy_accum_mode_config.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_energy_accum_mode_config;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, power_vld_i, pulse_vld_i;
  logic act_pulse_neg_i, react_pulse_neg_i, fault_mode_i, tamper_b_i, act_accum_vld_o, react_accum_vld_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i, w;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [4:0] cur_gain_o, volt_gain_o;
  logic signed [31:0] act_power_i, react_power_i, cur_a_i, cur_b_i, volt_i;
  logic signed [31:0] act_accum_o, react_accum_o, cur_sample_o, volt_sample_o;
  logic [7:0] ix [4] = '{8'h0f, 8'h1b, 8'h3d, 8'h20};
  logic [7:0] mk [4] = '{8'h7f, 8'hef, 8'h3c, 8'h00};
  logic [7:0] wv [4] = '{8'hff, 8'hff, 8'h3c, 8'hff};
  int miscompares = 0, checked = 0, cyc = 0, p;
  eam_config eam_config_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .act_power_i(act_power_i), .react_power_i(react_power_i),
    .power_vld_i(power_vld_i), .act_pulse_neg_i(act_pulse_neg_i), .react_pulse_neg_i(react_pulse_neg_i),
    .pulse_vld_i(pulse_vld_i), .fault_mode_i(fault_mode_i), .tamper_b_i(tamper_b_i), .cur_a_i(cur_a_i),
    .cur_b_i(cur_b_i), .volt_i(volt_i), .act_accum_o(act_accum_o), .react_accum_o(react_accum_o),
    .act_accum_vld_o(act_accum_vld_o), .react_accum_vld_o(react_accum_vld_o), .cur_sample_o(cur_sample_o),
    .volt_sample_o(volt_sample_o), .cur_gain_o(cur_gain_o), .volt_gain_o(volt_gain_o));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // one classic cycle; read data lands in q
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, wr, a, 2'b00, 24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : bus
  // reference shaping of one power sample
  task automatic feed(input int a, input int r, input logic [3:0] m);
    int ea, er;
    ea = m[0] ? (a < 0 ? -a : a) : m[1] ? (a > 0 ? a : 0) : a;
    er = m[3] ? (r < 0 ? -r : r) : m[2] ? (a < 0 ? -r : r) : r;
    {act_power_i, react_power_i, power_vld_i} <= {a, r, 1'b1};
    @(posedge clk_i);
    power_vld_i <= 0;
    @(negedge clk_i);
    chk(ea, act_accum_o);
    chk(er, react_accum_o);
    chk(32'h3, {30'h0, act_accum_vld_o, react_accum_vld_o});
    @(posedge clk_i);
  endtask : feed
  task final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, power_vld_i, pulse_vld_i} = 6'h20;
    {act_pulse_neg_i, react_pulse_neg_i, fault_mode_i, tamper_b_i, wb_adr_i, wb_dat_i} = '0;
    {act_power_i, react_power_i, cur_a_i, cur_b_i, volt_i} = '0;
    wb_sel_i = 4'hf;
    void'($urandom(32'hfc1f));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    for (int k = 0; k < 4; k++) begin
      bus(ix[k], 0, 8'h00);
      chk(32'h0, q);
      bus(ix[k], 1, wv[k]);
      bus(ix[k], 0, 8'h00);
      chk({24'h0, mk[k]}, q);
    end
    $display("register test done");
    for (int c = 0; c < 5; c++) begin
      bus(8'h1b, 1, {c[2:0], 2'b00, 3'(4 - c)});
      @(negedge clk_i);
      chk(32'h1 << c, {27'h0, volt_gain_o});
      chk(32'h10 >> c, {27'h0, cur_gain_o});
      @(posedge clk_i);
    end
    $display("gain test done");
    for (int m = 0; m < 16; m++) begin
      bus(8'h0f, 1, 8'(m));
      feed($urandom, $urandom, 4'(m));
    end
    $display("mode test done");
    bus(8'h41, 1, 8'h07);
    for (int s = 0; s < 2; s++) begin
      p = s ? -5 : 5;
      bus(8'h0f, 1, s ? 8'h30 : 8'h00);
      feed(p, p, 4'h0);
      bus(8'h40, 0, 8'h00);
      feed(-p, -p, 4'h0);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(32'h1, {31'h0, irq_o});
      @(posedge clk_i);
      bus(8'h40, 0, 8'h00);
      chk(32'h3, q);
      feed(p, p, 4'h0);
      bus(8'h40, 0, 8'h00);
      chk(32'h0, q);
    end
    $display("sign test done");
    bus(8'h41, 1, 8'h00);
    for (int s = 0; s < 2; s++) begin
      bus(8'h0f, 1, s ? 8'h40 : 8'h00);
      for (int f = 1; f >= 0; f--) begin
        fault_mode_i <= f[0];
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk(32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        bus(8'h40, 0, 8'h00);
        chk((s == f) ? 32'h0 : 32'h4, q);
      end
    end
    $display("fault test done");
    bus(8'h1b, 1, 8'h08);
    for (int n = 0; n < 2; n++) begin
      {act_pulse_neg_i, react_pulse_neg_i, pulse_vld_i} <= {n[0], n[0], 1'b1};
      @(posedge clk_i);
      pulse_vld_i <= 0;
      @(posedge clk_i);
    end
    bus(8'h40, 0, 8'h00);
    chk(32'h3, q);
    $display("pulse sign test done");
    {cur_a_i, cur_b_i, volt_i} <= {$urandom, $urandom, $urandom};
    for (int c = 0; c < 16; c++) begin
      w = c[3:0];
      bus(8'h3d, 1, {2'b00, w, 2'b00});
      @(negedge clk_i);
      chk(w[0] ? 32'h0 : w[3:2] == 2'h2 ? cur_b_i : cur_a_i, cur_sample_o);
      chk(w[1] ? 32'h0 : volt_i, volt_sample_o);
      @(posedge clk_i);
    end
    tamper_b_i <= 1;
    @(posedge clk_i);
    tamper_b_i <= 0;
    bus(8'h3d, 1, 8'h00);
    @(negedge clk_i);
    chk(cur_b_i, cur_sample_o);
    @(posedge clk_i);
    bus(8'h0f, 0, 8'h00);
    chk(32'hc0, q);
    bus(8'h42, 0, 8'h00);
    chk(32'h1, q);
    $display("input select test done");
    final_report;
  end
endmodule : tb_energy_accum_mode_config
`default_nettype wire
